// ==== hdl/qdpc_pkg.sv ====
// Constants, register map and state codes for the quad converter host controller.
// Assumes a 100 MHz pclk; shared by the controller, its checker, the model and the bench.
package qdpc_pkg;

	// Widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int CH_W = 2;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_DATA = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_CMD = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_INBUF = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_OUTBUF = 12'h020;

	// Control fields
	localparam int CTRL_AWAKE_BIT = 0;
	localparam int CTRL_AUTO_BIT = 1;
	localparam int CTRL_LOWV_BIT = 2;
	localparam int CTRL_RST_BIT = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 4'h0;

	// Data word fields
	localparam int DATA_CH_LSB = 16;

	// Command fields
	localparam int CMD_UPDATE_BIT = 0;

	// Status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_READY_BIT = 1;
	localparam int STAT_SUPPLY_BIT = 2;
	localparam int STAT_DONE_BIT = 3;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_5V_NS = 2500;
	localparam int WAKE_3V_NS = 5000;
	localparam int WAKE_5V_CYC = (WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_3V_CYC = (WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = 2;
	localparam int PULSE_CYC = 2;
	localparam int HOLD_CYC = 2;
	localparam int REST_CYC = 2;

	// Sequencer states
	typedef enum logic [6:0] {
		S_OFF = 7'b000_0001,
		S_IDLE = 7'b000_0010,
		S_SETUP = 7'b000_0100,
		S_SEL = 7'b000_1000,
		S_HOLD = 7'b001_0000,
		S_UPD = 7'b010_0000,
		S_REST = 7'b100_0000
	} qdpc_state_e;

endpackage

// ==== hdl/qdpc_timer.sv ====
// Down-counting phase timer with a one-cycle done pulse.
// Assumes start and load come from the same clock domain.
`timescale 1ns/100ps
module qdpc_timer #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic [CNT_W-1:0] load,
	// Status
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		count_nxt = count_r;
		done_nxt = 1'b0;
		if (start) begin
			count_nxt = load;
		end else if (count_r != '0) begin
			count_nxt = count_r - 1'b1;
			done_nxt = (count_r == {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
			done_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = (count_r != '0);
	assign done = done_r;
endmodule

// ==== hdl/qdpc_ctrl.sv ====
// Host-side controller for a quad 16-bit parallel-input converter.
// Assumes APB master on pclk; supply-good inputs synchronous to pclk.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module qdpc_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [qdpc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply monitors
	input wire logic interface_supply,
	input wire logic analog_supply,
	// Converter data bus
	output logic [qdpc_pkg::DATA_W-1:0] dac_data_o,
	output logic dac_data_oe,
	input wire logic [qdpc_pkg::DATA_W-1:0] dac_data_i,
	// Converter control pins
	output logic dac_sel_n,
	output logic dac_dir,
	output logic channel_select_low,
	output logic channel_select_high,
	output logic output_update_strobe,
	output logic sleep_control_n,
	output logic dac_reset
);
	import qdpc_pkg::*;

	// APB and software-visible state
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [DATA_W+CH_W-1:0] word_r, word_nxt;
	logic pend_wr_r, pend_wr_nxt;
	logic pend_upd_r, pend_upd_nxt;
	logic done_r, done_nxt;

	// Sequencer and pin state
	qdpc_state_e state_r, state_nxt;
	logic [DATA_W-1:0] data_r, data_nxt;
	logic oe_r, oe_nxt;
	logic sel_n_r, sel_n_nxt;
	logic [CH_W-1:0] ch_r, ch_nxt;
	logic upd_r, upd_nxt;
	logic sleep_n_r, sleep_n_nxt;
	logic rst_r, rst_nxt;
	logic ready_r, ready_nxt;
	logic [DATA_W-1:0] inbuf_r [NUM_CH];
	logic [DATA_W-1:0] inbuf_nxt [NUM_CH];
	logic [DATA_W-1:0] outbuf_r [NUM_CH];
	logic [DATA_W-1:0] outbuf_nxt [NUM_CH];

	// Timer hookups
	logic seq_start, seq_done;
	logic [CNT_W-1:0] seq_load;
	logic wake_start, wake_done;
	logic [CNT_W-1:0] wake_load;

	logic supply_ok;
	logic busy;
	logic access;
	logic seq_wr_taken;
	logic seq_upd_taken;
	logic seq_done_evt;

	assign supply_ok = interface_supply & analog_supply;
	assign busy = (state_r != S_IDLE) | pend_wr_r | pend_upd_r;
	assign access = psel & penable & pready_r;

	qdpc_timer #(
		.CNT_W(CNT_W)
	) u_seq_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(seq_start),
		.load(seq_load),
		.busy(),
		.done(seq_done)
	);

	qdpc_timer #(
		.CNT_W(CNT_W)
	) u_wake_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(wake_start),
		.load(wake_load),
		.busy(),
		.done(wake_done)
	);

	// APB decode and register writes
	always_comb begin
		pready_nxt = psel & penable & ~pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		ctrl_nxt = ctrl_r;
		word_nxt = word_r;
		pend_wr_nxt = pend_wr_r & ~seq_wr_taken;
		pend_upd_nxt = pend_upd_r & ~seq_upd_taken;
		done_nxt = done_r;
		if (pready_nxt) begin
			if (paddr == OFS_CTRL) begin
				prdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
			end else if (paddr == OFS_DATA) begin
				prdata_nxt = {{(32-DATA_W-CH_W){1'b0}}, word_r};
				pslverr_nxt = pwrite & busy;
			end else if (paddr == OFS_CMD) begin
				pslverr_nxt = pwrite & busy;
			end else if (paddr == OFS_STATUS) begin
				prdata_nxt[STAT_BUSY_BIT] = busy;
				prdata_nxt[STAT_READY_BIT] = ready_r;
				prdata_nxt[STAT_SUPPLY_BIT] = supply_ok;
				prdata_nxt[STAT_DONE_BIT] = done_r;
			end else if (paddr[ADDR_W-1:4] == OFS_INBUF[ADDR_W-1:4] && paddr[1:0] == 2'b00) begin
				prdata_nxt = {16'h0000, inbuf_r[paddr[3:2]]};
				pslverr_nxt = pwrite;
			end else if (paddr[ADDR_W-1:4] == OFS_OUTBUF[ADDR_W-1:4] && paddr[1:0] == 2'b00) begin
				prdata_nxt = {16'h0000, outbuf_r[paddr[3:2]]};
				pslverr_nxt = pwrite;
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		if (access && pwrite && !pslverr_r) begin
			if (paddr == OFS_CTRL) begin
				ctrl_nxt = pwdata[CTRL_W-1:0];
			end else if (paddr == OFS_DATA) begin
				word_nxt = pwdata[DATA_W+CH_W-1:0];
				pend_wr_nxt = 1'b1;
			end else if (paddr == OFS_CMD) begin
				pend_upd_nxt = pwdata[CMD_UPDATE_BIT];
			end else if (paddr == OFS_STATUS && pwdata[STAT_DONE_BIT]) begin
				done_nxt = 1'b0;
			end
		end
		if (seq_done_evt) begin
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			ctrl_r <= CTRL_RST_VAL;
			word_r <= '0;
			pend_wr_r <= 1'b0;
			pend_upd_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			ctrl_r <= ctrl_nxt;
			word_r <= word_nxt;
			pend_wr_r <= pend_wr_nxt;
			pend_upd_r <= pend_upd_nxt;
			done_r <= done_nxt;
		end
	end

	// Pin sequencer
	always_comb begin
		state_nxt = state_r;
		data_nxt = data_r;
		oe_nxt = oe_r;
		sel_n_nxt = sel_n_r;
		ch_nxt = ch_r;
		upd_nxt = upd_r;
		sleep_n_nxt = ctrl_r[CTRL_AWAKE_BIT];
		rst_nxt = ctrl_r[CTRL_RST_BIT];
		ready_nxt = ready_r;
		inbuf_nxt = inbuf_r;
		outbuf_nxt = outbuf_r;
		seq_start = 1'b0;
		seq_load = '0;
		seq_wr_taken = 1'b0;
		seq_upd_taken = 1'b0;
		seq_done_evt = 1'b0;
		case (state_r)
			S_OFF: begin
				if (supply_ok) begin
					sel_n_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			S_IDLE: begin
				if (pend_wr_r) begin
					data_nxt = word_r[DATA_W-1:0];
					ch_nxt = word_r[DATA_CH_LSB +: CH_W];
					oe_nxt = 1'b1;
					seq_wr_taken = 1'b1;
					seq_start = 1'b1;
					seq_load = CNT_W'(SETUP_CYC);
					state_nxt = S_SETUP;
				end else if (pend_upd_r) begin
					upd_nxt = 1'b1;
					seq_upd_taken = 1'b1;
					seq_start = 1'b1;
					seq_load = CNT_W'(PULSE_CYC);
					state_nxt = S_UPD;
				end
			end
			S_SETUP: begin
				if (seq_done) begin
					sel_n_nxt = 1'b0;
					seq_start = 1'b1;
					seq_load = CNT_W'(PULSE_CYC);
					state_nxt = S_SEL;
				end
			end
			S_SEL: begin
				if (seq_done) begin
					sel_n_nxt = 1'b1;
					inbuf_nxt[ch_r] = data_r;
					seq_start = 1'b1;
					seq_load = CNT_W'(HOLD_CYC);
					state_nxt = S_HOLD;
				end
			end
			S_HOLD: begin
				if (seq_done) begin
					oe_nxt = 1'b0;
					if (ctrl_r[CTRL_AUTO_BIT]) begin
						upd_nxt = 1'b1;
						seq_start = 1'b1;
						seq_load = CNT_W'(PULSE_CYC);
						state_nxt = S_UPD;
					end else begin
						seq_done_evt = 1'b1;
						state_nxt = S_IDLE;
					end
				end
			end
			S_UPD: begin
				if (seq_done) begin
					upd_nxt = 1'b0;
					for (int i = 0; i < NUM_CH; i++) begin
						outbuf_nxt[i] = inbuf_r[i];
					end
					seq_start = 1'b1;
					seq_load = CNT_W'(REST_CYC);
					state_nxt = S_REST;
				end
			end
			S_REST: begin
				if (seq_done) begin
					seq_done_evt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_OFF;
			end
		endcase
		if (!supply_ok || state_r == S_OFF) begin
			state_nxt = supply_ok ? state_nxt : S_OFF;
			data_nxt = '0;
			oe_nxt = supply_ok ? 1'b0 : 1'b1;
			sel_n_nxt = supply_ok;
			ch_nxt = '0;
			upd_nxt = 1'b0;
			sleep_n_nxt = 1'b0;
			rst_nxt = 1'b0;
			seq_wr_taken = pend_wr_r;
			seq_upd_taken = pend_upd_r;
			for (int i = 0; i < NUM_CH; i++) begin
				inbuf_nxt[i] = '0;
				outbuf_nxt[i] = '0;
			end
		end
		wake_start = sleep_n_nxt & ~sleep_n_r;
		wake_load = ctrl_r[CTRL_LOWV_BIT] ? CNT_W'(WAKE_3V_CYC) : CNT_W'(WAKE_5V_CYC);
		if (!sleep_n_nxt || wake_start) begin
			ready_nxt = 1'b0;
		end else if (wake_done) begin
			ready_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_OFF;
			data_r <= '0;
			oe_r <= 1'b1;
			sel_n_r <= 1'b0;
			ch_r <= '0;
			upd_r <= 1'b0;
			sleep_n_r <= 1'b0;
			rst_r <= 1'b0;
			ready_r <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				inbuf_r[i] <= '0;
				outbuf_r[i] <= '0;
			end
		end else begin
			state_r <= state_nxt;
			data_r <= data_nxt;
			oe_r <= oe_nxt;
			sel_n_r <= sel_n_nxt;
			ch_r <= ch_nxt;
			upd_r <= upd_nxt;
			sleep_n_r <= sleep_n_nxt;
			rst_r <= rst_nxt;
			ready_r <= ready_nxt;
			inbuf_r <= inbuf_nxt;
			outbuf_r <= outbuf_nxt;
		end
	end

	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign dac_data_o = data_r;
	assign dac_data_oe = oe_r;
	assign dac_sel_n = sel_n_r;
	assign dac_dir = 1'b0 & dac_data_i[0];
	assign channel_select_low = ch_r[0];
	assign channel_select_high = ch_r[1];
	assign output_update_strobe = upd_r;
	assign sleep_control_n = sleep_n_r;
	assign dac_reset = rst_r;
endmodule

// ==== verif/qdpc_ctrl_asserts.sv ====
// Pin checker for the quad converter host controller.
// Assumes binding onto qdpc_ctrl, one pclk domain.
`timescale 1ns/100ps
module qdpc_ctrl_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Supplies
	input wire logic interface_supply,
	input wire logic analog_supply,
	// Converter pins
	input wire logic [qdpc_pkg::DATA_W-1:0] dac_data_o,
	input wire logic dac_data_oe,
	input wire logic dac_sel_n,
	input wire logic dac_dir,
	input wire logic output_update_strobe,
	input wire logic sleep_control_n,
	input wire logic dac_reset
);
	import qdpc_pkg::*;
	wire sup = interface_supply && analog_supply;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_off_pins_low: assert property (
		!sup |=> !dac_sel_n && dac_data_oe && dac_data_o == '0 && !sleep_control_n
		&& !output_update_strobe && !dac_reset) else $error("pins not low unpowered");
	a_sel_pulse: assert property (
		$fell(dac_sel_n) && $past(dac_data_oe) |-> (!dac_sel_n) [*3] ##1 dac_sel_n)
		else $error("select pulse length wrong");
	a_data_held: assert property (
		$fell(dac_sel_n) && $past(dac_data_oe)
		|-> ($stable(dac_data_o) && dac_data_oe && !dac_dir) [*4])
		else $error("data not held at select");
	a_strobe_len: assert property (
		$rose(output_update_strobe) |-> output_update_strobe [*3] ##1 !output_update_strobe)
		else $error("strobe length wrong");
	a_strobe_after: assert property (
		$rose(output_update_strobe) |-> dac_sel_n && !dac_data_oe && sup)
		else $error("strobe during bus access");
	a_bus_release: assert property (
		$rose(dac_sel_n) && dac_data_oe |-> ##3 !dac_data_oe)
		else $error("data bus not released");
	a_sel_idle: assert property (
		sup && !dac_data_oe |-> dac_sel_n) else $error("select low while bus released");
endmodule

bind qdpc_ctrl qdpc_ctrl_asserts u_chk (.*);

// ==== verif/qdpc_dev_model.sv ====
// Converter model: input and output code registers, sleep and power.
// Assumes pins from the host controller; the device has no clock.
`timescale 1ns/100ps
module qdpc_dev_model (
	// Power
	input wire logic powered,
	// Bus and control pins
	input wire logic [qdpc_pkg::DATA_W-1:0] data,
	input wire logic sel_n,
	input wire logic dir,
	input wire logic ch_lo,
	input wire logic ch_hi,
	input wire logic upd,
	input wire logic sleep_n,
	// Observed state
	output logic [3:0][qdpc_pkg::DATA_W-1:0] codes,
	output logic out_on
);
	import qdpc_pkg::*;
	logic [3:0][DATA_W-1:0] inreg;
	initial begin
		inreg = '0;
		codes = '0;
	end
	always @(posedge powered) begin
		inreg = '0;
		codes = '0;
	end
	always @(negedge sel_n) begin
		if (powered && !dir)
			inreg[{ch_hi, ch_lo}] = data;
	end
	always @(posedge upd) begin
		if (powered)
			codes = inreg;
	end
	assign out_on = powered && sleep_n;
endmodule

// ==== verif/qdpc_ctrl_tb.sv ====
// Bench for the quad converter host controller against a converter model.
// Assumes package, controller, timer and model compiled first.
`timescale 1ns/100ps
module qdpc_ctrl_tb;
	import qdpc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic interface_supply, analog_supply, dac_data_oe, dac_sel_n, dac_dir, dac_reset, out_on;
	logic channel_select_low, channel_select_high, output_update_strobe, sleep_control_n;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [DATA_W-1:0] dac_data_o, dac_data_i;
	logic [3:0][DATA_W-1:0] codes, exp_c;
	int fails, checks, cyc;
	assign dac_data_i = dac_data_oe ? dac_data_o : ~dac_data_o;
	qdpc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .interface_supply, .analog_supply, .dac_data_o, .dac_data_oe,
		.dac_data_i, .dac_sel_n, .dac_dir, .channel_select_low, .channel_select_high,
		.output_update_strobe, .sleep_control_n, .dac_reset);
	qdpc_dev_model u_dev (.powered(interface_supply && analog_supply), .data(dac_data_i),
		.sel_n(dac_sel_n), .dir(dac_dir), .ch_lo(channel_select_low),
		.ch_hi(channel_select_high), .upd(output_update_strobe), .sleep_n(sleep_control_n),
		.codes, .out_on);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		checks++;
		if (g !== x) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic xe);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			complete_run();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pslverr", xe, err_q);
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			acc(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0);
			n++;
		end while (rd_q[b] !== v && n < 100);
		if (n >= 100) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic t_power();
		acc(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0);
		chk("supply_bit", 1'b0, rd_q[STAT_SUPPLY_BIT]);
		acc(1'b1, OFS_DATA, 32'h0000_1234, 1'b1);
		acc(1'b0, 12'h0FC, 32'h0000_0000, 1'b1);
		interface_supply <= 1'b1;
		analog_supply <= 1'b1;
		poll(STAT_SUPPLY_BIT, 1'b1);
		chk("codes_zero", 64'h0, codes);
	endtask
	task automatic t_write();
		acc(1'b1, OFS_CTRL, 32'h0000_0001, 1'b0);
		for (int c = 0; c < NUM_CH; c++) begin
			exp_c[c] = 16'h0F0F + 16'h2101 * c[15:0];
			acc(1'b1, OFS_DATA, {14'h0000, c[1:0], exp_c[c]}, 1'b0);
			poll(STAT_BUSY_BIT, 1'b0);
		end
		chk("codes_before_update", 64'h0, codes);
		acc(1'b1, OFS_CMD, 32'h0000_0001, 1'b0);
		poll(STAT_BUSY_BIT, 1'b0);
		chk("codes_updated", exp_c, codes);
	endtask
	task automatic t_sleep();
		int t0;
		acc(1'b1, OFS_CTRL, 32'h0000_0000, 1'b0);
		repeat (2) @(posedge pclk);
		chk("out_on_sleep", 1'b0, out_on);
		chk("codes_sleep", exp_c, codes);
		acc(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0);
		chk("ready_sleep", 1'b0, rd_q[STAT_READY_BIT]);
		acc(1'b1, OFS_CTRL, 32'h0000_0001, 1'b0);
		t0 = cyc;
		poll(STAT_READY_BIT, 1'b1);
		chk("wake_delay", 1'b1, cyc - t0 >= WAKE_5V_CYC && cyc - t0 <= WAKE_5V_CYC + 12);
		chk("out_on_wake", 1'b1, out_on);
		chk("codes_wake", exp_c, codes);
	endtask
	task automatic t_auto();
		acc(1'b1, OFS_CTRL, 32'h0000_0003, 1'b0);
		exp_c[2] = 16'hBEEF;
		acc(1'b1, OFS_DATA, {16'h0002, exp_c[2]}, 1'b0);
		acc(1'b1, OFS_DATA, 32'h0001_5555, 1'b1);
		poll(STAT_BUSY_BIT, 1'b0);
		chk("codes_auto", exp_c, codes);
		acc(1'b0, OFS_OUTBUF + 12'h008, 32'h0000_0000, 1'b0);
		chk("outbuf_c", exp_c[2], rd_q[15:0]);
		acc(1'b0, OFS_INBUF + 12'h004, 32'h0000_0000, 1'b0);
		chk("inbuf_b", exp_c[1], rd_q[15:0]);
		acc(1'b1, OFS_CTRL, 32'h0000_000B, 1'b0);
		repeat (2) @(posedge pclk);
		chk("reset_pin", 1'b1, dac_reset);
		chk("sleep_pin", 1'b1, sleep_control_n);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		interface_supply = 1'b0;
		analog_supply = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_power();
		t_write();
		t_sleep();
		t_auto();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		complete_run();
	end
endmodule
